// file: csm_pkg.sv
package csm_pkg;
    localparam int DATA_W = 32;
    localparam int CNT_W = 5;
    localparam logic [15:0] EXTEND_PREFIX = 16'h0007;
    // AHB register map
    localparam logic [7:0] ADDR_OPA = 8'h00;
    localparam logic [7:0] ADDR_OPB = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_RES_D = 8'h10;
    localparam logic [7:0] ADDR_RES_S = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Flag bit positions
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_B = 3;
    // Control field layout
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_EXT_BIT = 4;
    localparam int CTRL_SIZE_LSB = 5;
    localparam int CTRL_MEM_BIT = 7;
    localparam int CTRL_GO_BIT = 8;
    typedef enum logic [2:0] {
        CSM_OP_ROTL = 3'h0,
        CSM_OP_SHL = 3'h1,
        CSM_OP_SHRA = 3'h2,
        CSM_OP_SUB = 3'h3,
        CSM_OP_DIV = 3'h4,
        CSM_OP_MUL = 3'h5
    } csm_op_t;
    typedef enum logic [1:0] {
        CSM_SZ_BYTE = 2'h0,
        CSM_SZ_WORD = 2'h1,
        CSM_SZ_QUAD = 2'h2
    } csm_size_t;
    typedef struct packed {
        logic [31:0] dst;
        logic [31:0] src;
        logic [7:0] flags;
        logic div_zero;
    } csm_result_t;
endpackage : csm_pkg

// file: csm_alu.sv
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module csm_alu (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic div_zero_exc
);
    logic [31:0] opa;
    logic [31:0] opb;
    logic [8:0] ctrl;
    logic [7:0] condition_flags;
    logic [31:0] res_d;
    logic [31:0] res_s;
    logic dz_seen;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic prefix_armed;

    // Address phase capture
    wire addr_take = hsel && hready && htrans[1];
    wire wr_go = ap_valid && ap_write;
    wire wr_opa = wr_go && (ap_addr == csm_pkg::ADDR_OPA);
    wire wr_opb = wr_go && (ap_addr == csm_pkg::ADDR_OPB);
    wire wr_ctrl = wr_go && (ap_addr == csm_pkg::ADDR_CTRL);
    wire wr_flags = wr_go && (ap_addr == csm_pkg::ADDR_FLAGS);
    // Writing the control word with a go bit executes in its data phase
    wire go = wr_ctrl && hwdata[csm_pkg::CTRL_GO_BIT];
    // Writing ctrl with the ext bit set and the go bit clear arms the extend state
    wire wr_prefix = wr_ctrl && !hwdata[csm_pkg::CTRL_GO_BIT] && hwdata[csm_pkg::CTRL_EXT_BIT];
    wire [2:0] op_code = hwdata[csm_pkg::CTRL_OP_LSB +: 3];
    wire ext = hwdata[csm_pkg::CTRL_EXT_BIT] || prefix_armed;
    wire [1:0] size = hwdata[csm_pkg::CTRL_SIZE_LSB +: 2];
    wire mem_dst = hwdata[csm_pkg::CTRL_MEM_BIT];

    wire [4:0] cnt = opb[4:0];
    wire cin = condition_flags[csm_pkg::FLAG_C];
    wire [2:0] keep_low = condition_flags[2:0];

    // Rotate left
    wire [63:0] rot_dbl = {opa, opa} << cnt;
    wire [31:0] rot_res = rot_dbl[63:32];
    wire rot_c = (cnt == 5'h00) ? 1'b0 : rot_res[0];
    // Left shift, spill collects into upper word
    wire [63:0] shl_dbl = {32'h0000_0000, opa} << cnt;
    wire [31:0] shl_res = shl_dbl[31:0];
    wire shl_c = (cnt == 5'h00) ? 1'b0 : shl_dbl[32];
    wire [31:0] shl_src = ext ? shl_dbl[63:32] : opb;
    // Arithmetic right shift
    wire [63:0] sra_dbl = $signed({opa, 32'h0000_0000}) >>> cnt;
    wire [31:0] sra_res = sra_dbl[63:32];
    wire sra_c = (cnt == 5'h00) ? 1'b0 : sra_dbl[31];

    // Subtract, evaluated at destination width
    wire [32:0] sub_full = {1'b0, opa} - {1'b0, opb} - {32'h0000_0000, ext & cin};
    wire [31:0] sub_res = sub_full[31:0];
    wire [4:0] msb_i = !mem_dst ? 5'h1F : (size == csm_pkg::CSM_SZ_BYTE) ? 5'h07 :
                       (size == csm_pkg::CSM_SZ_WORD) ? 5'h0F : 5'h1F;
    wire [31:0] wmask = !mem_dst ? 32'hFFFF_FFFF : (size == csm_pkg::CSM_SZ_BYTE) ? 32'h0000_00FF :
                        (size == csm_pkg::CSM_SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    wire [31:0] sub_bits = {opa ^ opb ^ sub_res};
    wire sub_c = (msb_i == 5'h1F) ? sub_full[32] : sub_bits[msb_i + 5'h01];
    wire sub_s = sub_res[msb_i];
    wire sub_v = (opa[msb_i] ^ opb[msb_i]) & (opa[msb_i] ^ sub_res[msb_i]);
    wire sub_zr = (sub_res & wmask) == 32'h0000_0000;
    wire sub_z = ext ? (condition_flags[csm_pkg::FLAG_Z] & sub_zr) : sub_zr;
    wire sub_b = ((opa & wmask) == 32'h0000_0000) || ((opb & wmask) == 32'h0000_0000);

    // Divide
    wire div_zero = (opb == 32'h0000_0000);
    wire div_ovf = (opa == 32'h8000_0000) && (opb == 32'hFFFF_FFFF);
    wire [31:0] q = div_zero || div_ovf ? 32'h0000_0000 : 32'($signed(opa) / $signed(opb));
    wire [31:0] r = div_zero || div_ovf ? 32'h0000_0000 : 32'($signed(opa) % $signed(opb));
    wire [31:0] div_d = div_ovf ? 32'h8000_0000 : q;
    wire [7:0] div_f = {cin, div_d == 32'h0000_0000, div_d[31], div_ovf, 1'b0, keep_low};

    // Multiply
    wire [63:0] prod = 64'($signed(opa) * $signed(opb));
    wire [7:0] mul_f = {cin, prod == 64'h0, prod[63], 1'b0, 1'b0, keep_low};

    function automatic logic [7:0] shf(input logic [31:0] v, input logic c, input logic [2:0] k);
        shf = {c, v == 32'h0000_0000, v[31], c ^ v[31], 1'b0, k};
    endfunction : shf

    csm_pkg::csm_result_t nxt;
    always_comb begin
        nxt = '{dst: opa, src: opb, flags: condition_flags, div_zero: 1'b0};
        case (csm_pkg::csm_op_t'(op_code))
            csm_pkg::CSM_OP_ROTL: nxt = '{rot_res, opb, shf(rot_res, rot_c, keep_low), 1'b0};
            csm_pkg::CSM_OP_SHL: nxt = '{shl_res, shl_src, shf(shl_res, shl_c, keep_low), 1'b0};
            csm_pkg::CSM_OP_SHRA: nxt = '{sra_res, opb, shf(sra_res, sra_c, keep_low), 1'b0};
            csm_pkg::CSM_OP_SUB: nxt = '{(opa & ~wmask) | (sub_res & wmask), opb,
                                        {sub_c, sub_z, sub_s, sub_v, sub_b, keep_low}, 1'b0};
            csm_pkg::CSM_OP_DIV: begin
                if (div_zero) begin
                    nxt = '{opa, opb, condition_flags, 1'b1};
                end else begin
                    nxt = '{div_d, r, div_f, 1'b0};
                end
            end
            csm_pkg::CSM_OP_MUL: nxt = '{prod[31:0], prod[63:32], mul_f, 1'b0};
            default: nxt = '{opa, opb, condition_flags, 1'b0};
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_valid <= addr_take;
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opa <= 32'h0000_0000;
            opb <= 32'h0000_0000;
            ctrl <= 9'h000;
        end else begin
            if (wr_opa) opa <= hwdata;
            if (wr_opb) opb <= hwdata;
            if (wr_ctrl) ctrl <= hwdata[8:0];
        end
    end

    // Prefix lasts for exactly one following operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prefix_armed <= 1'b0;
        end else if (go) begin
            prefix_armed <= 1'b0;
        end else if (wr_prefix) begin
            prefix_armed <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            condition_flags <= csm_pkg::FLAGS_RESET;
            res_d <= 32'h0000_0000;
            res_s <= 32'h0000_0000;
            dz_seen <= 1'b0;
            div_zero_exc <= 1'b0;
        end else begin
            div_zero_exc <= go && nxt.div_zero;
            if (go) begin
                condition_flags <= nxt.flags;
                res_d <= nxt.dst;
                res_s <= nxt.src;
                dz_seen <= nxt.div_zero;
            end else if (wr_flags) begin
                condition_flags <= hwdata[7:0];
            end
        end
    end

    // Read path registered to keep outputs straight from flops
    wire [31:0] rd_mux = (haddr[7:0] == csm_pkg::ADDR_OPA) ? opa :
                         (haddr[7:0] == csm_pkg::ADDR_OPB) ? opb :
                         (haddr[7:0] == csm_pkg::ADDR_CTRL) ? {23'h0, ctrl} :
                         (haddr[7:0] == csm_pkg::ADDR_FLAGS) ? {24'h0, condition_flags} :
                         (haddr[7:0] == csm_pkg::ADDR_RES_D) ? res_d :
                         (haddr[7:0] == csm_pkg::ADDR_RES_S) ? res_s :
                         (haddr[7:0] == csm_pkg::ADDR_STAT) ? {30'h0, prefix_armed, dz_seen} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_take && !hwrite) hrdata <= rd_mux;
        end
    end

    property p_dz_hold;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code == csm_pkg::CSM_OP_DIV && opb == 32'h0 |=> div_zero_exc && $stable(condition_flags);
    endproperty
    div_zero_hold_a: assert property (p_dz_hold) else $error("divide by zero changed state");
    property p_prefix_once;
        @(posedge hclk) disable iff (!hresetn) go |=> !prefix_armed;
    endproperty
    prefix_once_a: assert property (p_prefix_once) else $error("prefix survived an operation");
    property p_mul_flags;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code == csm_pkg::CSM_OP_MUL |=> !condition_flags[csm_pkg::FLAG_V] && !condition_flags[csm_pkg::FLAG_B]
            && condition_flags[csm_pkg::FLAG_S] == res_s[31];
    endproperty
    mul_flags_a: assert property (p_mul_flags) else $error("multiply flags wrong");
    property p_shift_v;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code <= csm_pkg::CSM_OP_SHRA |=> condition_flags[csm_pkg::FLAG_V] ==
            (condition_flags[csm_pkg::FLAG_C] ^ res_d[31]) && !condition_flags[csm_pkg::FLAG_B];
    endproperty
    shift_flags_a: assert property (p_shift_v) else $error("shift flags wrong");
    property p_div_ovf;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code == csm_pkg::CSM_OP_DIV && div_ovf |=> res_d == 32'h8000_0000 && res_s == 32'h0
            && condition_flags[csm_pkg::FLAG_V] && !div_zero_exc;
    endproperty
    div_ovf_a: assert property (p_div_ovf) else $error("divide overflow case wrong");
    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
    endproperty
    bus_okay_a: assert property (p_bus_okay) else $error("bus answer not okay");
    property p_rot_src;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code == csm_pkg::CSM_OP_ROTL |=> res_s == $past(opb) && condition_flags[csm_pkg::FLAG_C] ==
            ($past(cnt) != 5'h0 && res_d[0]);
    endproperty
    rotate_src_a: assert property (p_rot_src) else $error("rotate changed source or carry");
    property p_div_c;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code == csm_pkg::CSM_OP_DIV |=> $stable(condition_flags[csm_pkg::FLAG_C]);
    endproperty
    div_carry_a: assert property (p_div_c) else $error("divide changed carry");

    // Operation strobes, true only in the data phase of a go write; s_dz_raised ends one cycle later
    sequence s_go_rot;
        go && op_code == csm_pkg::CSM_OP_ROTL;
    endsequence
    sequence s_go_shl;
        go && op_code == csm_pkg::CSM_OP_SHL;
    endsequence
    sequence s_go_sra;
        go && op_code == csm_pkg::CSM_OP_SHRA;
    endsequence
    sequence s_go_sub;
        go && op_code == csm_pkg::CSM_OP_SUB;
    endsequence
    sequence s_go_div;
        go && op_code == csm_pkg::CSM_OP_DIV;
    endsequence
    sequence s_go_mul;
        go && op_code == csm_pkg::CSM_OP_MUL;
    endsequence
    sequence s_dz_raised;
        s_go_div ##0 div_zero ##1 div_zero_exc;
    endsequence

    // Results are checked by undoing the operation, except the multiply product, which is recomputed
    property p_rot_undo;
        @(posedge hclk) disable iff (!hresetn)
        s_go_rot |=> 32'({res_d, res_d} >> $past(cnt)) == $past(opa) && res_s == $past(opb);
    endproperty
    rotate_value_a: assert property (p_rot_undo) else $error("rotate result wrong");
    property p_shl_plain;
        @(posedge hclk) disable iff (!hresetn)
        s_go_shl ##0 !ext |=> res_s == $past(opb)
            && (res_d >> $past(cnt)) == ($past(opa) & (32'hFFFF_FFFF >> $past(cnt)));
    endproperty
    shl_value_a: assert property (p_shl_plain) else $error("left shift result wrong");
    property p_shl_ext;
        @(posedge hclk) disable iff (!hresetn)
        s_go_shl ##0 ext |=> ({res_s, res_d} >> $past(cnt)) == {32'h0000_0000, $past(opa)};
    endproperty
    shl_spill_a: assert property (p_shl_ext) else $error("extended shift lost bits");
    property p_sra_val;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sra |=> res_s == $past(opb) && res_d[31] == $past(opa[31])
            && (res_d << $past(cnt)) == ($past(opa) & (32'hFFFF_FFFF << $past(cnt)));
    endproperty
    sra_value_a: assert property (p_sra_val) else $error("arithmetic shift result wrong");
    property p_shift_keep;
        @(posedge hclk) disable iff (!hresetn)
        go && op_code <= csm_pkg::CSM_OP_SHRA |=> condition_flags[2:0] == $past(condition_flags[2:0])
            && condition_flags[csm_pkg::FLAG_Z] == (res_d == 32'h0000_0000)
            && condition_flags[csm_pkg::FLAG_S] == res_d[31];
    endproperty
    shift_zs_a: assert property (p_shift_keep) else $error("shift zero or sign flag wrong");

    // Register destinations only, except the borrow zero check; narrow widths are covered below
    property p_sub_value;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 !mem_dst |=> 32'(res_d + $past(opb) + {31'h0, $past(ext & cin)}) == $past(opa)
            && res_s == $past(opb);
    endproperty
    sub_value_a: assert property (p_sub_value) else $error("subtract result wrong");
    property p_sub_borrow;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 !mem_dst |=> condition_flags[csm_pkg::FLAG_C] ==
            ({1'b0, $past(opa)} < 33'({1'b0, $past(opb)} + {32'h0000_0000, $past(ext & cin)}));
    endproperty
    sub_borrow_a: assert property (p_sub_borrow) else $error("subtract borrow wrong");
    property p_sbc_zero;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 ext && !condition_flags[csm_pkg::FLAG_Z] |=> !condition_flags[csm_pkg::FLAG_Z];
    endproperty
    sbc_zero_a: assert property (p_sbc_zero) else $error("borrow subtract set zero");
    property p_sub_opzero;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 !mem_dst |=> condition_flags[csm_pkg::FLAG_B] ==
            ($past(opa) == 32'h0000_0000 || $past(opb) == 32'h0000_0000);
    endproperty
    sub_opzero_a: assert property (p_sub_opzero) else $error("subtract operand zero flag wrong");
    property p_sub_byte;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 mem_dst && size == csm_pkg::CSM_SZ_BYTE |=> res_d[31:8] == $past(opa[31:8]);
    endproperty
    sub_byte_a: assert property (p_sub_byte) else $error("byte subtract touched upper bits");
    property p_sub_word;
        @(posedge hclk) disable iff (!hresetn)
        s_go_sub ##0 mem_dst && size == csm_pkg::CSM_SZ_WORD |=> res_d[31:16] == $past(opa[31:16]);
    endproperty
    sub_word_a: assert property (p_sub_word) else $error("word subtract touched upper bits");

    property p_div_math;
        @(posedge hclk) disable iff (!hresetn)
        s_go_div ##0 !div_zero && !div_ovf |=>
            32'($signed(res_d) * $signed($past(opb)) + $signed(res_s)) == $past(opa)
            && (res_s == 32'h0000_0000 || res_s[31] == $past(opa[31]));
    endproperty
    div_math_a: assert property (p_div_math) else $error("quotient and remainder disagree");
    property p_div_zero_regs;
        @(posedge hclk) disable iff (!hresetn)
        s_go_div ##0 div_zero |=> res_d == $past(opa) && res_s == $past(opb) && dz_seen;
    endproperty
    div_zero_regs_a: assert property (p_div_zero_regs) else $error("divide by zero changed registers");
    property p_dz_pulse;
        @(posedge hclk) disable iff (!hresetn) s_dz_raised ##0 !go |=> !div_zero_exc;
    endproperty
    dz_pulse_a: assert property (p_dz_pulse) else $error("divide by zero exception stuck");
    property p_div_flags;
        @(posedge hclk) disable iff (!hresetn)
        s_go_div ##0 !div_zero |=> condition_flags[csm_pkg::FLAG_Z] == (res_d == 32'h0000_0000)
            && condition_flags[csm_pkg::FLAG_S] == res_d[31] && !condition_flags[csm_pkg::FLAG_B]
            && condition_flags[2:0] == $past(condition_flags[2:0]);
    endproperty
    div_flags_a: assert property (p_div_flags) else $error("divide flags wrong");

    property p_mul_prod;
        @(posedge hclk) disable iff (!hresetn)
        s_go_mul |=> res_d == 32'($past(opa) * $past(opb))
            && condition_flags[csm_pkg::FLAG_Z] == ({res_s, res_d} == 64'h0000_0000_0000_0000);
    endproperty
    mul_prod_a: assert property (p_mul_prod) else $error("multiply product wrong");
    property p_mul_keep;
        @(posedge hclk) disable iff (!hresetn)
        s_go_mul |=> condition_flags[csm_pkg::FLAG_C] == $past(condition_flags[csm_pkg::FLAG_C])
            && condition_flags[2:0] == $past(condition_flags[2:0]);
    endproperty
    mul_keep_a: assert property (p_mul_keep) else $error("multiply changed kept flags");

    property p_prefix_arm;
        @(posedge hclk) disable iff (!hresetn) wr_prefix |=> prefix_armed;
    endproperty
    prefix_arm_a: assert property (p_prefix_arm) else $error("prefix failed to arm");
endmodule : csm_alu

// file: csm_host_model.sv
`timescale 1ns/1ps
module csm_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Decode side of the core: single whole-word transfers only
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Entered just after a rising edge; holds each phase until hready is seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdata = hrdata;
        // Stale write data would hide a late capture
        hwdata <= ~wdata;
    endtask : xfer
endmodule : csm_host_model

// file: csm_alu_test.sv
`timescale 1ns/1ps
module csm_alu_test;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic div_zero_exc;
    logic [31:0] rd;
    logic [31:0] stat;
    int n_mismatch = 0;
    int compares = 0;
    int n_dz = 0;
    int cycles = 0;

    csm_alu csm_alu_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .div_zero_exc(div_zero_exc));
    csm_host_model csm_host_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic give_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Whole run needs a few hundred cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (div_zero_exc === 1'b1) n_dz <= n_dz + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        csm_host_model_inst.xfer(1'b1, addr, data, rd);
    endtask : wr

    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
        csm_host_model_inst.xfer(1'b0, addr, 32'h0, rd);
        chk(rd, exp);
    endtask : rdc

    // Status read doubles as the spacer between go and the result reads
    task automatic run(input logic [31:0] opa, input logic [31:0] opb, input logic [31:0] ctrl,
        input logic [7:0] fin, input logic res, input logic [31:0] d, input logic [31:0] s, input logic [7:0] fout);
        wr(csm_pkg::ADDR_OPA, opa);
        wr(csm_pkg::ADDR_OPB, opb);
        wr(csm_pkg::ADDR_FLAGS, {24'h0, fin});
        wr(csm_pkg::ADDR_CTRL, ctrl);
        csm_host_model_inst.xfer(1'b0, csm_pkg::ADDR_STAT, 32'h0, stat);
        if (res) begin
            rdc(csm_pkg::ADDR_RES_D, d);
            rdc(csm_pkg::ADDR_RES_S, s);
        end
        rdc(csm_pkg::ADDR_FLAGS, {24'h0, fout});
    endtask : run

    initial begin
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(csm_pkg::ADDR_FLAGS, {24'h0, csm_pkg::FLAGS_RESET});
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0);
        run(32'h7F37_B2D3, 32'h24, 32'h100, 8'h4B, 1'b1, 32'hF37B_2D37, 32'h24, 8'hA3);
        run(32'h7F37_B2D3, 32'h04, 32'h101, 8'h03, 1'b1, 32'hF37B_2D30, 32'h04, 8'hA3);
        run(32'h7F37_B2D3, 32'h04, 32'h111, 8'h03, 1'b1, 32'hF37B_2D30, 32'h07, 8'hA3);
        run(32'h8F37_B2D3, 32'h04, 32'h102, 8'h83, 1'b1, 32'hF8F3_7B2D, 32'h04, 8'h33);
        wr(csm_pkg::ADDR_CTRL, 32'h013);
        rdc(csm_pkg::ADDR_STAT, 32'h2);
        run(32'h16, 32'h20, 32'h103, 8'h83, 1'b1, 32'hFFFF_FFF5, 32'h20, 8'hA3);
        run(32'h16, 32'h20, 32'h103, 8'h83, 1'b1, 32'hFFFF_FFF6, 32'h20, 8'hA3);
        run(32'h16, 32'h20, 32'h113, 8'h03, 1'b1, 32'hFFFF_FFF6, 32'h20, 8'hA3);
        run(32'h21, 32'h20, 32'h113, 8'hC0, 1'b1, 32'h0, 32'h20, 8'h40);
        run(32'h21, 32'h20, 32'h113, 8'h80, 1'b1, 32'h0, 32'h20, 8'h00);
        run(32'h8000_0000, 32'h1, 32'h113, 8'h00, 1'b1, 32'h7FFF_FFFF, 32'h1, 8'h10);
        run(32'h0, 32'h5, 32'h113, 8'h00, 1'b1, 32'hFFFF_FFFB, 32'h5, 8'hA8);
        run(32'h100, 32'h1, 32'h183, 8'h00, 1'b1, 32'h1FF, 32'h1, 8'hA8);
        run(32'h1_0000, 32'h1, 32'h1A3, 8'h00, 1'b1, 32'h1_FFFF, 32'h1, 8'hA8);
        run(32'hFFFF_FFE5, 32'h5, 32'h104, 8'hC3, 1'b1, 32'hFFFF_FFFB, 32'hFFFF_FFFE, 8'hA3);
        run(32'h3, 32'h5, 32'h104, 8'h00, 1'b1, 32'h0, 32'h3, 8'h40);
        run(32'h8000_0000, 32'hFFFF_FFFF, 32'h104, 8'h08, 1'b1, 32'h8000_0000, 32'h0, 8'h30);
        chk(n_dz, 0);
        run(32'h5, 32'h0, 32'h104, 8'h9B, 1'b1, 32'h5, 32'h0, 8'h9B);
        chk(stat & 32'h1, 32'h1);
        chk(n_dz, 1);
        run(32'hFFFF_FFE5, 32'h5, 32'h105, 8'h93, 1'b1, 32'hFFFF_FF79, 32'hFFFF_FFFF, 8'hA3);
        run(32'h0, 32'h5, 32'h105, 8'h03, 1'b1, 32'h0, 32'h0, 8'h43);
        chk({31'h0, hresp}, 32'h0);
        give_verdict();
    end
endmodule : csm_alu_test
